// ==== fsp_core.v ====
/*
 fsp_core: serial flash command framing and sector
 protection, with a classic wishbone register slave.
 assumes the host drives ce_n, sck and the data lines,
 sck slower than clk_i / 4, and the array read port
 answering combinationally on array_addr_o.
*/
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "fsp_consts.vh"
module fsp_core #(
	parameter [15:0] UNLOCK_CYC = `FSP_UNLOCK_US * `FSP_CLK_MHZ
) (
	// system
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// serial link pins
	input wire ce_n_i,
	input wire sck_i,
	input wire hw_rst_n_i,
	input wire [3:0] quad_data_lines_i,
	output reg [3:0] quad_data_lines_o,
	output reg [3:0] quad_data_lines_oe_n_o,
	// array read port
	output reg [31:0] array_addr_o,
	input wire [7:0] array_data_i
);

localparam S_INS = 3'd0;
localparam S_ADR = 3'd1;
localparam S_MOD = 3'd2;
localparam S_DUM = 3'd3;
localparam S_DIN = 3'd4;
localparam S_DOUT = 3'd5;
localparam S_DONE = 3'd6;
localparam S_IGN = 3'd7;

// shift one lane group into a byte
function [7:0] shin;
	input [7:0] s;
	input [3:0] d;
	input [2:0] w;
	begin
		case (w)
		3'd1: shin = {s[6:0], d[0]};
		3'd2: shin = {s[5:0], d[1:0]};
		default: shin = {s[3:0], d};
		endcase
	end
endfunction

// place the top lane group on the pins
function [3:0] outg;
	input [7:0] s;
	input [2:0] w;
	begin
		case (w)
		3'd1: outg = {2'b00, s[7], 1'b0};
		3'd2: outg = {2'b00, s[7:6]};
		default: outg = s[7:4];
		endcase
	end
endfunction

function [3:0] oen;
	input [2:0] w;
	begin
		case (w)
		3'd1: oen = 4'b1101;
		3'd2: oen = 4'b1100;
		default: oen = 4'b0000;
		endcase
	end
endfunction

// opcode to {kind, width, dtr, four byte address}
function [8:0] dec;
	input [7:0] op;
	begin
		case (op)
		`FSP_OP_READ: dec = {`FSP_K_READ, 3'd1, 2'b00};
		`FSP_OP_FAST: dec = {`FSP_K_READ, 3'd1, 2'b00};
		`FSP_OP_DUAL_IO: dec = {`FSP_K_READ, 3'd2, 2'b00};
		`FSP_OP_QUAD_IO: dec = {`FSP_K_READ, 3'd4, 2'b00};
		`FSP_OP_QUAD_DTR: dec = {`FSP_K_READ, 3'd4, 2'b10};
		`FSP_OP_RD_DYN: dec = {`FSP_K_RDDYN, 3'd1, 2'b00};
		`FSP_OP_WR_DYN: dec = {`FSP_K_WRDYN, 3'd1, 2'b00};
		`FSP_OP_RD_PERS: dec = {`FSP_K_RDPERS, 3'd1, 2'b00};
		`FSP_OP_PG_PERS: dec = {`FSP_K_PGPERS, 3'd1, 2'b00};
		`FSP_OP_RD_DYN4: dec = {`FSP_K_RDDYN, 3'd1, 2'b01};
		`FSP_OP_WR_DYN4: dec = {`FSP_K_WRDYN, 3'd1, 2'b01};
		`FSP_OP_RD_PERS4: dec = {`FSP_K_RDPERS, 3'd1, 2'b01};
		`FSP_OP_PG_PERS4: dec = {`FSP_K_PGPERS, 3'd1, 2'b01};
		`FSP_OP_ER_PERS: dec = {`FSP_K_ERPERS, 3'd1, 2'b00};
		`FSP_OP_WR_LOCK: dec = {`FSP_K_WRLOCK, 3'd1, 2'b00};
		`FSP_OP_PW_RD: dec = {`FSP_K_PWRD, 3'd1, 2'b00};
		`FSP_OP_PW_PGM: dec = {`FSP_K_PWPGM, 3'd1, 2'b00};
		`FSP_OP_PW_UNLK: dec = {`FSP_K_UNLK, 3'd1, 2'b00};
		`FSP_OP_MODE_RD: dec = {`FSP_K_MODERD, 3'd1, 2'b00};
		`FSP_OP_MODE_PGM: dec = {`FSP_K_MODEPGM, 3'd1, 2'b00};
		`FSP_OP_RD_STAT: dec = {`FSP_K_RDST, 3'd1, 2'b00};
		`FSP_OP_CLR_STAT: dec = {`FSP_K_CLST, 3'd1, 2'b00};
		`FSP_OP_SW_RST: dec = {`FSP_K_SWRST, 3'd1, 2'b00};
		default: dec = {`FSP_K_NONE, 3'd1, 2'b00};
		endcase
	end
endfunction

reg [2:0] sck_s;
reg [1:0] ce_s;
reg [1:0] hr_s;
reg [3:0] io_a;
reg [3:0] io_b;
reg ce_d;
reg [2:0] st;
reg [3:0] kind;
reg [2:0] w;
reg dtr;
reg a4;
reg hasm;
reg dum;
reg cont;
reg [7:0] ish;
reg [2:0] bc;
reg [3:0] nby;
reg [31:0] addr;
reg [7:0] dat;
reg [63:0] pwb;
reg [7:0] osh;
reg [2:0] ocnt;
reg oact;
reg [3:0] dleft;
reg [255:0] dynamic_protect_bit;
reg [255:0] persistent_protect_bit;
reg lock;
reg [7:0] protection_mode_register;
reg [63:0] pw;
reg perr;
reg prot;
reg [15:0] wcnt;
reg [3:0] dcfg;
reg [7:0] idx;
reg sw_p;
reg clr_p;
reg [7:0] src;
reg [31:0] rd;

// synchronisers, first stage read only by the second
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		sck_s <= 3'b000;
		ce_s <= 2'b11;
		hr_s <= 2'b11;
		io_a <= 4'h0;
		io_b <= 4'h0;
	end
	else
	begin
		sck_s <= {sck_s[1:0], sck_i};
		ce_s <= {ce_s[0], ce_n_i};
		hr_s <= {hr_s[0], hw_rst_n_i};
		io_a <= quad_data_lines_i;
		io_b <= io_a;
	end
end

wire rise = sck_s[1] & ~sck_s[2];
wire fall = ~sck_s[1] & sck_s[2];
wire ce_lo = ~ce_s[1];
wire ce_fall = ce_lo & ce_d;
wire ce_rise = ce_s[1] & ~ce_d;
wire in_ph = (st != S_DUM) && (st != S_DOUT) && (st != S_IGN);
wire ev_in = ce_lo & in_ph & (rise | (dtr & fall));
wire ev_out = ce_lo & (st == S_DOUT) & (fall | (dtr & oact & rise));
wire [3:0] bsum = {1'b0, bc} + {1'b0, w};
wire [3:0] osum = {1'b0, ocnt} + {1'b0, w};
wire [7:0] nb = shin(ish, io_b, w);
wire [8:0] dv = dec(nb);
wire [3:0] dkind = dv[8:5];
wire [3:0] nby1 = nby + 4'd1;
wire [7:0] blk = addr[23:16];
wire write_in_progress_flag = (wcnt != 16'h0000);
wire pwm = ~protection_mode_register[`FSP_MODE_PWLK];
wire [3:0] mc = (w == 3'd4) ? (dtr ? 4'd1 : 4'd2) : (dtr ? 4'd2 : 4'd4);
wire [3:0] dl = (dcfg > mc) ? dcfg - mc : 4'd0;
wire pwk = (kind == `FSP_K_UNLK) || (kind == `FSP_K_PWPGM);
wire [3:0] need = pwk ? 4'd8 : 4'd1;
wire [7:0] stat = {3'b000, pwm, lock, prot, perr, write_in_progress_flag};
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

// byte returned in the data out phase
always @*
begin
	case (kind)
	`FSP_K_READ: src = array_data_i;
	`FSP_K_RDDYN: src = {8{dynamic_protect_bit[blk]}};
	`FSP_K_RDPERS: src = {8{persistent_protect_bit[blk]}};
	`FSP_K_MODERD: src = protection_mode_register;
	`FSP_K_PWRD: src = pw[{addr[2:0], 3'b000} +: 8];
	default: src = stat;
	endcase
end

// link framing and protection state
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		ce_d <= 1'b1;
		st <= S_INS;
		kind <= `FSP_K_NONE;
		w <= 3'd1;
		dtr <= 1'b0;
		a4 <= 1'b0;
		hasm <= 1'b0;
		dum <= 1'b0;
		cont <= 1'b0;
		ish <= 8'h00;
		bc <= 3'd0;
		nby <= 4'd0;
		addr <= 32'h0;
		dat <= 8'h00;
		pwb <= 64'h0;
		osh <= 8'h00;
		ocnt <= 3'd0;
		oact <= 1'b0;
		dleft <= 4'd0;
		dynamic_protect_bit <= {256{1'b1}};
		persistent_protect_bit <= {256{1'b1}};
		lock <= 1'b1;
		protection_mode_register <= `FSP_MODE_RST;
		pw <= {64{1'b1}};
		perr <= 1'b0;
		prot <= 1'b0;
		wcnt <= 16'h0000;
		array_addr_o <= 32'h0;
		quad_data_lines_o <= 4'h0;
		quad_data_lines_oe_n_o <= 4'hf;
	end
	else if (~hr_s[1])
	begin
		ce_d <= 1'b1;
		st <= S_INS;
		cont <= 1'b0;
		dynamic_protect_bit <= {256{1'b1}};
		lock <= ~pwm;
		perr <= 1'b0;
		prot <= 1'b0;
		wcnt <= 16'h0000;
		quad_data_lines_oe_n_o <= 4'hf;
	end
	else
	begin
		ce_d <= ce_s[1];
		if (write_in_progress_flag)
			wcnt <= wcnt - 16'h0001;
		if (clr_p)
		begin
			perr <= 1'b0;
			prot <= 1'b0;
		end
		if (sw_p)
			dynamic_protect_bit <= {256{1'b1}};
		if (ce_fall)
		begin
			bc <= 3'd0;
			nby <= 4'd0;
			ocnt <= 3'd0;
			oact <= 1'b0;
			addr <= 32'h0;
			if (cont)
				st <= write_in_progress_flag ? S_IGN : S_ADR;
			else
			begin
				st <= S_INS;
				w <= 3'd1;
				dtr <= 1'b0;
			end
		end
		else if (ce_rise)
		begin
			st <= S_INS;
			quad_data_lines_oe_n_o <= 4'hf;
			if (kind != `FSP_K_READ)
				cont <= 1'b0;
			if (st == S_DONE && bc == 3'd0)
			begin
				case (kind)
				`FSP_K_WRDYN:
					dynamic_protect_bit[blk] <= (dat == 8'hff);
				`FSP_K_PGPERS:
					if (lock)
					begin
						persistent_protect_bit[blk] <= 1'b0;
						wcnt <= `FSP_PGM_CYC;
					end
					else
					begin
						perr <= 1'b1;
						prot <= 1'b1;
					end
				`FSP_K_ERPERS:
					if (lock)
					begin
						persistent_protect_bit <= {256{1'b1}};
						wcnt <= `FSP_ERS_CYC;
					end
					else
					begin
						perr <= 1'b1;
						prot <= 1'b1;
					end
				`FSP_K_WRLOCK:
					lock <= 1'b0;
				`FSP_K_PWPGM:
				begin
					pw <= pw & pwb;
					wcnt <= `FSP_PGM_CYC;
				end
				`FSP_K_UNLK:
					if (pwm && pwb == pw)
					begin
						lock <= 1'b1;
						wcnt <= 16'h0001;
					end
					else if (pwm)
					begin
						perr <= 1'b1;
						prot <= 1'b1;
						wcnt <= UNLOCK_CYC;
					end
				`FSP_K_MODEPGM:
				begin
					protection_mode_register <= protection_mode_register & dat;
					wcnt <= `FSP_PGM_CYC;
				end
				`FSP_K_CLST:
				begin
					perr <= 1'b0;
					prot <= 1'b0;
				end
				`FSP_K_SWRST:
				begin
					dynamic_protect_bit <= {256{1'b1}};
					perr <= 1'b0;
					prot <= 1'b0;
				end
				default:
					dat <= dat;
				endcase
			end
		end
		else if (ev_in)
		begin
			ish <= nb;
			bc <= bsum[2:0];
			if (bsum[3])
			begin
				case (st)
				S_INS:
				begin
					kind <= dkind;
					w <= dv[4:2];
					dtr <= dv[1];
					a4 <= dv[0];
					hasm <= (dv[4:2] != 3'd1);
					dum <= (nb != `FSP_OP_READ);
					cont <= 1'b0;
					if (write_in_progress_flag && dkind != `FSP_K_RDST)
						st <= S_IGN;
					else
					begin
						case (dkind)
						`FSP_K_NONE: st <= S_IGN;
						`FSP_K_READ, `FSP_K_RDDYN, `FSP_K_WRDYN,
						`FSP_K_RDPERS, `FSP_K_PGPERS: st <= S_ADR;
						`FSP_K_PWRD: st <= pwm ? S_IGN : S_DOUT;
						`FSP_K_PWPGM: st <= pwm ? S_IGN : S_DIN;
						`FSP_K_UNLK, `FSP_K_MODEPGM: st <= S_DIN;
						`FSP_K_RDST, `FSP_K_MODERD: st <= S_DOUT;
						default: st <= S_DONE;
						endcase
					end
				end
				S_ADR:
				begin
					addr <= {addr[23:0], nb};
					nby <= nby1;
					if (nby1 == (a4 ? 4'd4 : 4'd3))
					begin
						nby <= 4'd0;
						array_addr_o <= {addr[23:0], nb};
						case (kind)
						`FSP_K_READ:
							if (hasm)
								st <= S_MOD;
							else if (dum && dcfg != 4'd0)
							begin
								st <= S_DUM;
								dleft <= dcfg;
							end
							else
								st <= S_DOUT;
						`FSP_K_WRDYN: st <= S_DIN;
						`FSP_K_PGPERS: st <= S_DONE;
						default: st <= S_DOUT;
						endcase
					end
				end
				S_MOD:
				begin
					cont <= (nb[7:4] == `FSP_CONT_NIB);
					dleft <= dl;
					st <= (dl == 4'd0) ? S_DOUT : S_DUM;
				end
				S_DIN:
				begin
					dat <= nb;
					pwb <= {nb, pwb[63:8]};
					nby <= nby1;
					if (nby1 == need)
						st <= S_DONE;
				end
				default:
					nby <= nby;
				endcase
			end
		end
		else if (ev_out)
		begin
			oact <= 1'b1;
			ocnt <= osum[2:0];
			quad_data_lines_oe_n_o <= oen(w);
			if (ocnt == 3'd0)
			begin
				quad_data_lines_o <= outg(src, w);
				osh <= src << w;
				addr <= addr + 32'h1;
				array_addr_o <= array_addr_o + 32'h1;
			end
			else
			begin
				quad_data_lines_o <= outg(osh, w);
				osh <= osh << w;
			end
		end
		else if (ce_lo && rise && st == S_DUM)
		begin
			dleft <= dleft - 4'd1;
			if (dleft <= 4'd1)
				st <= S_DOUT;
		end
	end
end

// register read mux
always @*
begin
	case ({wb_adr_i[7:2], 2'b00})
	`FSP_REG_STAT: rd = {24'h0, stat};
	`FSP_REG_CTRL: rd = {28'h0, dcfg};
	`FSP_REG_IDX: rd = {24'h0, idx};
	`FSP_REG_SECT: rd = {29'h0, persistent_protect_bit[idx] & dynamic_protect_bit[idx], persistent_protect_bit[idx], dynamic_protect_bit[idx]};
	`FSP_REG_MODE: rd = {24'h0, protection_mode_register};
	default: rd = 32'h0;
	endcase
end

// wishbone slave, one wait state
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0;
		dcfg <= `FSP_DUMMY_RST;
		idx <= 8'h00;
		sw_p <= 1'b0;
		clr_p <= 1'b0;
	end
	else
	begin
		wb_ack_o <= wb_req;
		sw_p <= 1'b0;
		clr_p <= 1'b0;
		if (wb_req)
			wb_dat_o <= rd;
		if (wb_req && wb_we_i && wb_sel_i[0])
		begin
			case ({wb_adr_i[7:2], 2'b00})
			`FSP_REG_CTRL:
			begin
				dcfg <= wb_dat_i[3:0];
				sw_p <= wb_dat_i[`FSP_CTRL_SWRST];
				clr_p <= wb_dat_i[`FSP_CTRL_CLR];
			end
			`FSP_REG_IDX:
				idx <= wb_dat_i[7:0];
			default:
				idx <= idx;
			endcase
		end
	end
end

endmodule // fsp_core

// ==== fsp_consts.vh ====
/*
 fsp_consts.vh: constants of the serial flash command
 front end with sector protection.
 assumes inclusion by bare name from the core file.
*/
// Functional notes
// - unprotected only when both protect bits one
// - reset of any kind restores dynamic bits
// - lock zero blocks persistent bits, dynamic free
// - persistent mode lock rises only by reset
// - persistent mode lock set on resets; software resets (CTRL bit, 0x99) leave lock unchanged
// - lock write command clears lock
// - password mode: lock cleared, unlock sets
// - password ships ones, programming only clears
// - password mode locked: password access ignored
// - mode bits are one-time programmable
// - wrong password sets both error flags
// - unlock attempts spaced by busy time
// - matching password skips busy delay
// - instruction byte first, msb first
// - sample rising edges, both in dtr
// - address msb first, data address increments
// - instruction fixes lane width thereafter
// - continuation mode skips instruction byte
// - dummy cycles include mode cycles
// - busy device ignores reads, most commands
// - persistent bits program singly, erase together
// - locked persistent program or erase fails
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
// opcodes
`define FSP_OP_READ 8'h03
`define FSP_OP_FAST 8'h0b
`define FSP_OP_DUAL_IO 8'hbb
`define FSP_OP_QUAD_IO 8'heb
`define FSP_OP_QUAD_DTR 8'hed
`define FSP_OP_RD_DYN 8'hfa
`define FSP_OP_WR_DYN 8'hfb
`define FSP_OP_RD_PERS 8'hfc
`define FSP_OP_PG_PERS 8'hfd
`define FSP_OP_RD_DYN4 8'he0
`define FSP_OP_WR_DYN4 8'he1
`define FSP_OP_RD_PERS4 8'he2
`define FSP_OP_PG_PERS4 8'he3
`define FSP_OP_ER_PERS 8'he4
`define FSP_OP_WR_LOCK 8'ha6
`define FSP_OP_PW_RD 8'he7
`define FSP_OP_PW_PGM 8'he8
`define FSP_OP_PW_UNLK 8'he9
`define FSP_OP_MODE_RD 8'h2b
`define FSP_OP_MODE_PGM 8'h2f
`define FSP_OP_RD_STAT 8'h05
`define FSP_OP_CLR_STAT 8'h30
`define FSP_OP_SW_RST 8'h99
// command kinds
`define FSP_K_NONE 4'h0
`define FSP_K_READ 4'h1
`define FSP_K_RDDYN 4'h2
`define FSP_K_WRDYN 4'h3
`define FSP_K_RDPERS 4'h4
`define FSP_K_PGPERS 4'h5
`define FSP_K_ERPERS 4'h6
`define FSP_K_WRLOCK 4'h7
`define FSP_K_PWPGM 4'h8
`define FSP_K_PWRD 4'h9
`define FSP_K_UNLK 4'ha
`define FSP_K_MODEPGM 4'hb
`define FSP_K_MODERD 4'hc
`define FSP_K_RDST 4'hd
`define FSP_K_CLST 4'he
`define FSP_K_SWRST 4'hf
// fields and values
`define FSP_CONT_NIB 4'ha
`define FSP_MODE_PWLK 2
`define FSP_MODE_RST 8'hff
`define FSP_DUMMY_RST 4'h8
// timing
`define FSP_CLK_MHZ 50
`define FSP_UNLOCK_US 100
`define FSP_PGM_CYC 16'h0040
`define FSP_ERS_CYC 16'h0100
// wishbone byte addresses and control bit positions
`define FSP_REG_STAT 8'h00
`define FSP_REG_CTRL 8'h04
`define FSP_REG_IDX 8'h08
`define FSP_REG_SECT 8'h0c
`define FSP_REG_MODE 8'h10
`define FSP_CTRL_SWRST 4
`define FSP_CTRL_CLR 5
`endif

// ==== fsp_core_monitor.sv ====
/* fsp_core_monitor: port assertions for fsp_core.
 assumes a bind onto fsp_core. */
`timescale 1ns/1ps
module fsp_core_monitor (
	// system
	input wire clk_i,
	input wire rst_i,
	// wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// link
	input wire ce_n_i,
	input wire [3:0] quad_data_lines_oe_n_o
);
	reg [7:0] mode_seen;
	wire rd_ack = wb_ack_o && !wb_we_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// AND of all mode values read so far
	always @(posedge clk_i)
	begin
		if (rst_i)
			mode_seen <= 8'hff;
		else if (rd_ack && wb_adr_i[7:2] == 6'h04)
			mode_seen <= mode_seen & wb_dat_o[7:0];
	end
	a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_unmapped_zero: assert property (rd_ack && wb_adr_i[7:2] > 6'h04 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_sect_state: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h03 |-> wb_dat_o == {29'h0, &wb_dat_o[1:0], wb_dat_o[1:0]})
		else $error("sector state wrong");
	a_ctrl_selfclear: assert property (rd_ack && wb_adr_i[7:2] == 6'h01 |-> wb_dat_o[31:4] == 28'h0)
		else $error("control pulse bits read back");
	a_mode_otp: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h04 |-> (wb_dat_o[7:0] & ~mode_seen) == 8'h00)
		else $error("mode bit erased");
	a_lane_width: assert property (
		quad_data_lines_oe_n_o inside {4'hf, 4'hd, 4'hc, 4'h0})
		else $error("illegal lane enables");
	a_oe_released: assert property (ce_n_i [*6] |-> quad_data_lines_oe_n_o == 4'hf)
		else $error("lines driven while deselected");
	cover property (rd_ack && wb_adr_i[7:2] == 6'h03 && wb_dat_o[1:0] == 2'b10);
	cover property (quad_data_lines_oe_n_o == 4'hd);
	cover property (rd_ack && wb_adr_i[7:2] == 6'h00 && wb_dat_o[0]);
endmodule // fsp_core_monitor
bind fsp_core fsp_core_monitor u_fsp_core_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ce_n_i(ce_n_i), .quad_data_lines_oe_n_o(quad_data_lines_oe_n_o));

// ==== fsp_host.sv ====
/* fsp_host: single width link host.
 assumes clk_i at 50 MHz; sck of 8 clk, idle low. */
`timescale 1ns/1ps
module fsp_host (
	// system
	input wire clk_i,
	// link
	input wire line_i,
	output reg ce_n_o,
	output reg sck_o,
	output reg [3:0] io_o
);
	initial
	begin
		ce_n_o = 1'b1;
		sck_o = 1'b0;
		io_o = 4'h5;
	end
	// n bits msb first on io0, reply shifted from io1
	task frame(input integer n, input [71:0] tx, output [7:0] rx);
		integer i;
	begin
		rx = 8'h00;
		ce_n_o <= 1'b0;
		for (i = 0; i < n; i = i + 1)
		begin
			io_o <= {~io_o[3:1], tx[71 - i]};
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			rx = {rx[6:0], line_i};
			sck_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		ce_n_o <= 1'b1;
		io_o <= ~io_o;
		repeat (12) @(posedge clk_i);
	end
	endtask
endmodule // fsp_host

// ==== fsp_core_test.sv ====
/* fsp_core_test: self-checking bench of fsp_core.
 assumes fsp_host on the link. */
`timescale 1ns/1ps
module fsp_core_test;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg hw_rst_n = 1'b1;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h00;
	reg [31:0] wdat = 32'h0;
	reg [31:0] d;
	reg [7:0] rx;
	integer error_cnt = 0;
	integer checks = 0;
	wire [31:0] rdat;
	wire [31:0] aa;
	wire [3:0] hv;
	wire [3:0] dv;
	wire [3:0] oe_n;
	wire ack;
	wire ce_n;
	wire sck;
	wire [3:0] line = (~oe_n & dv) | (oe_n & hv);
	fsp_core #(.UNLOCK_CYC(16'd40)) u_fsp_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ce_n_i(ce_n), .sck_i(sck), .hw_rst_n_i(hw_rst_n), .quad_data_lines_i(line), .quad_data_lines_o(dv),
		.quad_data_lines_oe_n_o(oe_n), .array_addr_o(aa), .array_data_i(aa[7:0] ^ 8'h3c));
	fsp_host u_fsp_host (.clk_i(clk_i), .line_i(line[1]), .ce_n_o(ce_n), .sck_o(sck), .io_o(hv));
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	task end_sim;
	begin
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			error_cnt = error_cnt + 1;
			$display("unexpected %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task wb(input w, input [7:0] a, input [31:0] v);
		integer n;
	begin
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20)
		begin
			n = n + 1;
			@(posedge clk_i);
		end
		d = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
		if (n == 20)
		begin
			error_cnt = error_cnt + 1;
			$display("unexpected ack timeout exp 1 got 0");
			end_sim;
		end
	end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [63:0] nm);
	begin
		wb(1'b0, a, 32'h0);
		chk(e, d, nm);
	end
	endtask
	task f(input integer n, input [71:0] tx);
	begin
		u_fsp_host.frame(n, tx, rx);
	end
	endtask
	// poll status until not busy
	task idle;
		integer k;
	begin
		k = 0;
		wb(1'b0, 8'h00, 32'h0);
		while (d[0] !== 1'b0 && k < 200)
		begin
			k = k + 1;
			wb(1'b0, 8'h00, 32'h0);
		end
		if (k == 200)
		begin
			error_cnt = error_cnt + 1;
			$display("unexpected busy timeout exp 0 got 1");
			end_sim;
		end
	end
	endtask
	task hwr;
	begin
		hw_rst_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		hw_rst_n <= 1'b1;
		repeat (6) @(posedge clk_i);
	end
	endtask
	task s_reset;
	begin
		rd(8'h00, 32'h08, "status");
		rd(8'h10, 32'hff, "mode");
		rd(8'h04, 32'h08, "ctrl");
		rd(8'h14, 32'h00, "unmapped");
		f(16, {8'h05, 64'h0});
		chk(32'h08, {24'h0, rx}, "link_st");
		wb(1'b1, 8'h08, 32'h05);
		rd(8'h0c, 32'h07, "sect");
	end
	endtask
	task s_dyn;
	begin
		f(36, {8'hfb, 24'h050000, 40'h0});
		rd(8'h0c, 32'h07, "sect");
		f(40, {8'hfb, 24'h050000, 40'h0});
		rd(8'h0c, 32'h02, "sect");
		f(40, {8'hfa, 24'h050000, 40'h0});
		chk(32'h00, {24'h0, rx}, "dyn_read");
		f(40, {8'h03, 24'h000010, 40'h0});
		chk(32'h2c, {24'h0, rx}, "arr_read");
		wb(1'b1, 8'h04, 32'h18);
		rd(8'h0c, 32'h07, "sect");
		rd(8'h00, 32'h08, "status");
	end
	endtask
	task s_pers;
	begin
		f(32, {8'hfd, 24'h050000, 40'h0});
		idle;
		rd(8'h0c, 32'h01, "sect");
		f(8, {8'he4, 64'h0});
		f(40, {8'hfb, 24'h050000, 40'h0});
		idle;
		rd(8'h0c, 32'h07, "sect");
		f(8, {8'ha6, 64'h0});
		rd(8'h00, 32'h00, "status");
		f(32, {8'hfd, 24'h050000, 40'h0});
		idle;
		rd(8'h00, 32'h06, "status");
		rd(8'h0c, 32'h07, "sect");
		f(40, {8'hfb, 24'h050000, 40'h0});
		rd(8'h0c, 32'h02, "sect");
		wb(1'b1, 8'h04, 32'h38);
		rd(8'h00, 32'h00, "status");
		hwr;
		rd(8'h00, 32'h08, "status");
		rd(8'h0c, 32'h07, "sect");
	end
	endtask
	task s_pw;
	begin
		f(72, {8'he8, {8{8'ha5}}});
		idle;
		f(72, {8'he8, {8{8'hff}}});
		idle;
		f(72, {8'he7, 64'h0});
		chk(32'ha5, {24'h0, rx}, "pw_read");
		f(16, {8'h2f, 8'hfb, 56'h0});
		idle;
		f(16, {8'h2f, 8'hff, 56'h0});
		idle;
		rd(8'h10, 32'hfb, "mode");
		f(72, {8'he8, 64'h0});
		hwr;
		rd(8'h00, 32'h10, "status");
		f(72, {8'he9, 64'h0});
		rd(8'h00, 32'h17, "status");
		idle;
		wb(1'b1, 8'h04, 32'h28);
		f(72, {8'he9, {8{8'ha5}}});
		rd(8'h00, 32'h18, "status");
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		s_reset;
		s_dyn;
		s_pers;
		s_pw;
		end_sim;
	end
endmodule // fsp_core_test
